// ### hdl/lep_top.sv
// Lane equalization preset register bank for a pair of lane-pair registers
`timescale 1ns/1ps
`default_nettype none

module lep_top #(
  parameter int NUM_LANES = lep_pkg::NUM_LANES
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // Configuration access
  input  wire logic                   cfg_rd,
  input  wire logic                   cfg_wr,
  input  wire logic [11:0]            cfg_addr,
  output logic      [31:0]            cfg_rdata,
  output logic                        cfg_ack,
  // Port setup, same clock
  input  wire logic                   is_ds,
  input  wire logic                   transparent,
  input  wire logic                   xlink_en,
  // Management loader
  input  wire logic                   ldr_wr,
  input  wire logic [1:0]             ldr_lane,
  input  wire logic [1:0]             ldr_sel,
  input  wire logic [3:0]             ldr_data,
  // Link training state
  input  wire logic                   eq_phase1,
  input  wire logic                   in_rcvrcfg,
  // Received equalization TS2s, per lane
  input  wire logic [NUM_LANES-1:0]   rx_vld,
  input  wire logic [4*NUM_LANES-1:0] rx_preset,
  input  wire logic [3*NUM_LANES-1:0] rx_hint,
  // Transmitter and TS2 generator
  output logic      [4*NUM_LANES-1:0] tx_preset_r,
  output logic                        ts2_en_r,
  output logic      [4*NUM_LANES-1:0] ts2_preset_r,
  output logic      [3*NUM_LANES-1:0] ts2_hint_r
);

  // --------------------------------------------------------------------------
  // Per-lane storage
  // --------------------------------------------------------------------------
  logic [4*NUM_LANES-1:0]      ds_txp1_all;
  logic [3*NUM_LANES-1:0]      ds_rxh_all;
  logic [4*NUM_LANES-1:0]      ds_ts2p_all;
  logic [3*NUM_LANES-1:0]      ds_ts2h_all;
  logic [4*NUM_LANES-1:0]      us_ts2p_all;
  logic [3*NUM_LANES-1:0]      us_ts2h_all;
  logic [16*NUM_LANES-1:0]     half_all;

  // Same-clock loader and link inputs: no synchroniser needed
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LANES; gi = gi + 1) begin : g_lane
      wire lane_ld = ldr_wr && (ldr_lane == 2'(gi));

      lep_lane u_lane (
        .clk       (clk),
        .rst_b     (rst_b),
        .is_ds     (is_ds),
        .xlink_en  (xlink_en),
        .ldr_wr    (lane_ld),
        .ldr_sel   (ldr_sel),
        .ldr_data  (ldr_data),
        .rx_vld    (rx_vld[gi]),
        .rx_preset (rx_preset[4*gi +: 4]),
        .rx_hint   (rx_hint[3*gi +: 3]),
        .ds_txp1_r (ds_txp1_all[4*gi +: 4]),
        .ds_rxh_r  (ds_rxh_all[3*gi +: 3]),
        .ds_ts2p_r (ds_ts2p_all[4*gi +: 4]),
        .ds_ts2h_r (ds_ts2h_all[3*gi +: 3]),
        .us_ts2p_r (us_ts2p_all[4*gi +: 4]),
        .us_ts2h_r (us_ts2h_all[3*gi +: 3])
      );

      lep_half u_half (
        .is_ds   (is_ds),
        .ds_txp1 (ds_txp1_all[4*gi +: 4]),
        .ds_rxh  (ds_rxh_all[3*gi +: 3]),
        .ds_ts2p (ds_ts2p_all[4*gi +: 4]),
        .ds_ts2h (ds_ts2h_all[3*gi +: 3]),
        .us_ts2p (us_ts2p_all[4*gi +: 4]),
        .us_ts2h (us_ts2h_all[3*gi +: 3]),
        .half    (half_all[16*gi +: 16])
      );
    end
  endgenerate

  // Loader and link strobes are the only writers of the sticky fields
  sticky_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!ldr_wr && (rx_vld == '0)) |=>
      $stable(ds_txp1_all) && $stable(ds_rxh_all) &&
      $stable(ds_ts2p_all) && $stable(ds_ts2h_all))
    else $error("downstream field moved without a writer");

  loader_ts2p_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ldr_wr && (ldr_lane == 2'd2) && (ldr_sel == lep_pkg::LDR_TS2P)) |=>
      (ds_ts2p_all[11:8] == $past(ldr_data)))
    else $error("loader did not set TS2 preset");

  loader_ts2h_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ldr_wr && (ldr_lane == 2'd3) && (ldr_sel == lep_pkg::LDR_TS2H)) |=>
      (ds_ts2h_all[11:9] == $past(ldr_data[2:0])))
    else $error("loader did not set TS2 hint");

  // The spare select code must leave every field alone
  loader_none_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ldr_wr && (ldr_sel == lep_pkg::LDR_NONE) && (rx_vld == '0)) |=>
      $stable(ds_txp1_all) && $stable(ds_ts2p_all) && $stable(ds_ts2h_all))
    else $error("spare loader code changed a field");

  loader_lane_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ldr_wr && (ldr_lane == 2'd1)) |=>
      $stable(ds_txp1_all[3:0]) && $stable(ds_txp1_all[15:8]))
    else $error("loader wrote the wrong lane");

  // --------------------------------------------------------------------------
  // Configuration read decode
  // --------------------------------------------------------------------------
  // Even lane in the low half, odd lane in the high half
  wire        hit_a    = (cfg_addr == lep_pkg::OFF_PAIR_A);
  wire        hit_b    = (cfg_addr == lep_pkg::OFF_PAIR_B);
  wire [31:0] word_a   = half_all[31:0];
  wire [31:0] word_b   = half_all[63:32];
  wire [31:0] rd_word  = hit_a ? word_a :
                         hit_b ? word_b : lep_pkg::RD_ZERO;
  // Writes are acknowledged but change nothing; every field is read-only
  wire        cfg_req  = cfg_rd || cfg_wr;
  wire [31:0] rd_nxt   = cfg_rd ? rd_word : lep_pkg::RD_ZERO;

  // Answer one cycle after the request; unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= lep_pkg::RD_ZERO;
    end else begin
      cfg_ack   <= cfg_req;
      cfg_rdata <= rd_nxt;
    end
  end

  // Bus answer checks: one-cycle pulse, zero for writes and unmapped offsets
  ack_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg_req |=> !cfg_ack)
    else $error("config answer without a request");

  unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_rd && !hit_a && !hit_b) |=> (cfg_rdata == lep_pkg::RD_ZERO))
    else $error("unmapped offset read nonzero");

  write_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_wr && !cfg_rd) |=> (cfg_rdata == lep_pkg::RD_ZERO))
    else $error("config write returned data");

  pair_a_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_rd && hit_a && is_ds) |=>
      (cfg_rdata[19:16] == $past(ds_txp1_all[7:4])) &&
      (cfg_rdata[3:0] == $past(ds_txp1_all[3:0])))
    else $error("lane pair read misplaced");

  us_view_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_rd && hit_a && !is_ds) |=>
      (cfg_rdata[11:8] == $past(us_ts2p_all[3:0])) &&
      (cfg_rdata[30:28] == $past(us_ts2h_all[5:3])))
    else $error("upstream capture misplaced in read");

  ds_view_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_rd && hit_b && is_ds) |=>
      (cfg_rdata[11:8] == $past(ds_ts2p_all[11:8])) &&
      (cfg_rdata[30:28] == $past(ds_ts2h_all[11:9])))
    else $error("TS2 fields misplaced in read");

  // Upstream view hides the downstream-only low fields of both halves
  us_low_rsvd_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_rd && !is_ds) |=>
      (cfg_rdata[6:0] == 7'h00) && (cfg_rdata[22:16] == 7'h00))
    else $error("upstream reserved field read nonzero");

  // --------------------------------------------------------------------------
  // Transmit side
  // --------------------------------------------------------------------------
  // Only a transparent downstream port drives presets toward the link
  wire ds_active = is_ds && transparent;
  wire p1_apply  = ds_active && eq_phase1;
  wire ts2_send  = ds_active && in_rcvrcfg;

  // Holding the last applied preset avoids a glitch when phase 1 ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_preset_r <= '0;
    end else if (p1_apply) begin
      tx_preset_r <= ds_txp1_all;
    end
  end

  // Outside phase 1 the transmitters keep the last applied preset
  tx_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !p1_apply |=> $stable(tx_preset_r))
    else $error("transmit preset moved outside phase 1");

  // TS2 contents follow the stored fields while the generator is enabled.
  // The partner adopts them after the speed change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ts2_en_r     <= 1'b0;
      ts2_preset_r <= '0;
      ts2_hint_r   <= '0;
    end else begin
      ts2_en_r <= ts2_send;
      if (ts2_send) begin
        ts2_preset_r <= ds_ts2p_all;
        ts2_hint_r   <= ds_ts2h_all;
      end
    end
  end

  // Between send windows the TS2 contents keep their last value
  ts2_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ts2_send |=> $stable(ts2_preset_r) && $stable(ts2_hint_r))
    else $error("TS2 contents moved outside the send window");

  ts2_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ds_active && !in_rcvrcfg) |=> !ts2_en_r)
    else $error("TS2 enabled outside receiver configuration");

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // The answer is a single pulse one cycle after each request
  rd_answer_a: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_req |=> cfg_ack ##1 (!cfg_ack || $past(cfg_req)))
    else $error("config request not answered in one cycle");

  rsvd_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_ack |-> (cfg_rdata[31] == 1'b0) && (cfg_rdata[23] == 1'b0) &&
                (cfg_rdata[15] == 1'b0) && (cfg_rdata[7] == 1'b0))
    else $error("reserved bit read nonzero");

  write_noeff_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_wr && !ldr_wr && (rx_vld == '0)) |=>
      $stable(ds_txp1_all) && $stable(ds_ts2p_all) && $stable(us_ts2p_all))
    else $error("config write changed a field");

  pair_b_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg_rd && hit_b && is_ds) |=>
      (cfg_rdata[19:16] == $past(ds_txp1_all[15:12])) &&
      (cfg_rdata[3:0] == $past(ds_txp1_all[11:8])))
    else $error("lane pair read misplaced");

  loader_p1_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ldr_wr && (ldr_lane == 2'd1) && (ldr_sel == lep_pkg::LDR_TXP1)) |=>
      (ds_txp1_all[7:4] == $past(ldr_data)))
    else $error("loader did not set phase 1 preset");

  ds_hint_log_a: assert property (@(posedge clk) disable iff (!rst_b)
    (is_ds && rx_vld[2]) |=> (ds_rxh_all[8:6] == $past(rx_hint[8:6])) &&
      ($past(p1_apply) || $stable(tx_preset_r)))
    else $error("partner hint not logged or misused");

  us_pre_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!is_ds && !xlink_en && rx_vld[0]) |=>
      (us_ts2p_all[3:0] == $past(rx_preset[3:0])))
    else $error("upstream preset not captured");

  us_hint_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!is_ds && !xlink_en && rx_vld[1]) |=>
      (us_ts2h_all[5:3] == $past(rx_hint[5:3])))
    else $error("upstream hint not captured");

  xlink_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (xlink_en || is_ds) |=> $stable(us_ts2p_all) && $stable(us_ts2h_all))
    else $error("upstream capture moved while unused");

  p1_apply_a: assert property (@(posedge clk) disable iff (!rst_b)
    p1_apply |=> (tx_preset_r == $past(ds_txp1_all)))
    else $error("phase 1 preset not applied");

  ts2_send_a: assert property (@(posedge clk) disable iff (!rst_b)
    ts2_send |=> ts2_en_r && (ts2_preset_r == $past(ds_ts2p_all)))
    else $error("TS2 preset not sent");

  ts2_hint_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ts2_send ##1 ts2_send) |=> (ts2_hint_r == $past(ds_ts2h_all)) && ts2_en_r)
    else $error("TS2 hint not sent");

  ts2_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ds_active |=> !ts2_en_r)
    else $error("TS2 enabled on non-transparent port");

endmodule

`default_nettype wire

// ### pkg/lep_pkg.sv
// Constants and types shared by the lane equalization preset register bank
package lep_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] OFF_PAIR_A = 12'h130;  // Lanes 0 and 1 of this bank
  localparam logic [11:0] OFF_PAIR_B = 12'h134;  // Lanes 2 and 3 of this bank
  localparam int          NUM_LANES  = 4;
  localparam int          HALF_W     = 16;       // One lane per half word

  // --------------------------------------------------------------------------
  // Field layout inside one 16-bit half
  // --------------------------------------------------------------------------
  localparam int PRE_W     = 4;
  localparam int HINT_W    = 3;
  localparam int TXP1_LSB  = 0;   // Phase 1 transmitter preset (downstream)
  localparam int RXH_LSB   = 4;   // Hint returned by partner (downstream)
  localparam int RSV_LO    = 7;
  localparam int TS2P_LSB  = 8;   // Preset sent in TS2 / captured (upstream)
  localparam int TS2H_LSB  = 12;  // Hint sent in TS2 / captured (upstream)
  localparam int RSV_HI    = 15;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [3:0]  DS_PRE_RST  = 4'h0;
  localparam logic [2:0]  DS_HINT_RST = 3'h0;
  localparam logic [3:0]  US_PRE_RST  = 4'hF;
  localparam logic [2:0]  US_HINT_RST = 3'h7;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

  // --------------------------------------------------------------------------
  // Loader field select
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LDR_TXP1 = 2'b00,
    LDR_TS2P = 2'b01,
    LDR_TS2H = 2'b10,
    LDR_NONE = 2'b11
  } lep_ldr_sel_type;

endpackage

// ### hdl/lep_lane.sv
// Storage of the preset fields for one lane
`timescale 1ns/1ps
`default_nettype none

module lep_lane (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Port setup
  input  wire logic        is_ds,
  input  wire logic        xlink_en,
  // Loader, already decoded to this lane
  input  wire logic        ldr_wr,
  input  wire logic [1:0]  ldr_sel,
  input  wire logic [3:0]  ldr_data,
  // Received equalization TS2
  input  wire logic        rx_vld,
  input  wire logic [3:0]  rx_preset,
  input  wire logic [2:0]  rx_hint,
  // Stored fields
  output logic      [3:0]  ds_txp1_r,
  output logic      [2:0]  ds_rxh_r,
  output logic      [3:0]  ds_ts2p_r,
  output logic      [2:0]  ds_ts2h_r,
  output logic      [3:0]  us_ts2p_r,
  output logic      [2:0]  us_ts2h_r
);

  // --------------------------------------------------------------------------
  // Write enables
  // --------------------------------------------------------------------------
  // Loader touches only downstream fields; the partner's hint is logged only
  wire ld_txp1 = ldr_wr && (ldr_sel == lep_pkg::LDR_TXP1);
  wire ld_ts2p = ldr_wr && (ldr_sel == lep_pkg::LDR_TS2P);
  wire ld_ts2h = ldr_wr && (ldr_sel == lep_pkg::LDR_TS2H);
  wire ds_rec  = is_ds && rx_vld;
  wire us_cap  = !is_ds && !xlink_en && rx_vld;

  // Sticky fields: only the fundamental reset clears them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ds_txp1_r <= lep_pkg::DS_PRE_RST;
      ds_rxh_r  <= lep_pkg::DS_HINT_RST;
      ds_ts2p_r <= lep_pkg::DS_PRE_RST;
      ds_ts2h_r <= lep_pkg::DS_HINT_RST;
      us_ts2p_r <= lep_pkg::US_PRE_RST;
      us_ts2h_r <= lep_pkg::US_HINT_RST;
    end else begin
      if (ld_txp1) ds_txp1_r <= ldr_data;
      if (ld_ts2p) ds_ts2p_r <= ldr_data;
      if (ld_ts2h) ds_ts2h_r <= ldr_data[2:0];
      if (ds_rec)  ds_rxh_r  <= rx_hint;
      if (us_cap) begin
        us_ts2p_r <= rx_preset;
        us_ts2h_r <= rx_hint;
      end
    end
  end

endmodule

`default_nettype wire

// ### hdl/lep_half.sv
// Read view of one lane as a 16-bit half word
`timescale 1ns/1ps
`default_nettype none

module lep_half (
  // Port role
  input  wire logic        is_ds,
  // Stored fields
  input  wire logic [3:0]  ds_txp1,
  input  wire logic [2:0]  ds_rxh,
  input  wire logic [3:0]  ds_ts2p,
  input  wire logic [2:0]  ds_ts2h,
  input  wire logic [3:0]  us_ts2p,
  input  wire logic [2:0]  us_ts2h,
  // Formatted half
  output logic      [15:0] half
);

  // --------------------------------------------------------------------------
  // Layout: reserved bits 7 and 15 always read zero
  // --------------------------------------------------------------------------
  wire [3:0] f_lo_pre  = is_ds ? ds_txp1 : 4'h0;  // Reserved on upstream
  wire [2:0] f_lo_hint = is_ds ? ds_rxh  : 3'h0;
  wire [3:0] f_hi_pre  = is_ds ? ds_ts2p : us_ts2p;
  wire [2:0] f_hi_hint = is_ds ? ds_ts2h : us_ts2h;

  assign half = {1'b0, f_hi_hint, f_hi_pre, 1'b0, f_lo_hint, f_lo_pre};

endmodule

`default_nettype wire

// ### verification/lep_link_partner.sv
// Link partner model that returns equalization TS2s and adopts delivered presets
`timescale 1ns/1ps
`default_nettype none

module lep_link_partner (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // TS2 contents sent by the port
  input  wire logic        ts2_en,
  input  wire logic [15:0] ts2_preset,
  input  wire logic [11:0] ts2_hint,
  // TS2s returned to the port
  output logic      [3:0]  rx_vld,
  output logic      [15:0] rx_preset,
  output logic      [11:0] rx_hint,
  // Settings taken up after the speed change
  output logic      [15:0] adopt_preset,
  output logic      [11:0] adopt_hint
);
  logic [15:0] held_preset;
  logic [11:0] held_hint;
  logic        ts2_seen;

  initial begin
    rx_vld = 4'h0;
    rx_preset = 16'h0000;
    rx_hint = 12'h000;
  end

  // ----------------------------------------------------------------------
  // Return one TS2 on the chosen lanes
  // ----------------------------------------------------------------------
  // After a TS2 all lanes show inverted data so stale values never match
  task automatic send_ts2(input logic [3:0] lanes, input logic [3:0] pre, input logic [2:0] hnt);
    @(negedge clk);
    rx_vld = lanes;
    rx_preset = {4{pre}};
    rx_hint = {4{hnt}};
    @(negedge clk);
    rx_vld = 4'h0;
    rx_preset = ~rx_preset;
    rx_hint = ~rx_hint;
  endtask

  // ----------------------------------------------------------------------
  // Keep the last TS2 contents, adopt them once the TS2 phase ends
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ts2_seen <= 1'b0;
      held_preset <= 16'h0000;
      held_hint <= 12'h000;
      adopt_preset <= 16'h0000;
      adopt_hint <= 12'h000;
    end else begin
      ts2_seen <= ts2_en;
      if (ts2_en) begin
        held_preset <= ts2_preset;
        held_hint <= ts2_hint;
      end
      if (ts2_seen && !ts2_en) begin
        adopt_preset <= held_preset;
        adopt_hint <= held_hint;     // Optional use of the hint
      end
    end
  end
endmodule

`default_nettype wire

// ### verification/lane_equalization_preset_regs_bench.sv
// Self-checking bench for the lane equalization preset register bank
`timescale 1ns/1ps
`default_nettype none

module lane_equalization_preset_regs_bench;
  logic        clk, rst_b, cfg_rd, cfg_wr, cfg_ack, is_ds, transparent, xlink_en;
  logic        ldr_wr, eq_phase1, in_rcvrcfg, ts2_en_r;
  logic [11:0] cfg_addr, rx_hint, ts2_hint_r, adopt_hint;
  logic [31:0] cfg_rdata;
  logic [1:0]  ldr_lane, ldr_sel;
  logic [3:0]  ldr_data, rx_vld;
  logic [15:0] rx_preset, tx_preset_r, ts2_preset_r, adopt_preset;
  int          mismatches, comparisons, cycles;

  lep_top lep_top_i (.clk(clk), .rst_b(rst_b), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .is_ds(is_ds),
    .transparent(transparent), .xlink_en(xlink_en), .ldr_wr(ldr_wr), .ldr_lane(ldr_lane),
    .ldr_sel(ldr_sel), .ldr_data(ldr_data), .eq_phase1(eq_phase1), .in_rcvrcfg(in_rcvrcfg),
    .rx_vld(rx_vld), .rx_preset(rx_preset), .rx_hint(rx_hint), .tx_preset_r(tx_preset_r),
    .ts2_en_r(ts2_en_r), .ts2_preset_r(ts2_preset_r), .ts2_hint_r(ts2_hint_r));

  lep_link_partner lep_link_partner_i (.clk(clk), .rst_b(rst_b), .ts2_en(ts2_en_r),
    .ts2_preset(ts2_preset_r), .ts2_hint(ts2_hint_r), .rx_vld(rx_vld),
    .rx_preset(rx_preset), .rx_hint(rx_hint), .adopt_preset(adopt_preset),
    .adopt_hint(adopt_hint));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle request, answer expected exactly one cycle later
  task automatic cfg_access(input logic wr, input logic [11:0] addr, input logic [31:0] exp);
    @(negedge clk);
    cfg_rd = ~wr;
    cfg_wr = wr;
    cfg_addr = addr;
    @(negedge clk);
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    check("cfg_ack", {31'h0, cfg_ack}, 32'h1);
    check("cfg_rdata", cfg_rdata, exp);
  endtask

  task automatic load(input logic [1:0] lane, input logic [1:0] sel, input logic [3:0] data);
    @(negedge clk);
    ldr_wr = 1'b1;
    ldr_lane = lane;
    ldr_sel = sel;
    ldr_data = data;
    @(negedge clk);
    ldr_wr = 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_b, cfg_rd, cfg_wr, is_ds, transparent, ldr_wr, eq_phase1, in_rcvrcfg} = 8'h00;
    xlink_en = 1'b1;
    cfg_addr = 12'h000;
    {ldr_lane, ldr_sel, ldr_data} = 8'h00;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    // Upstream reset view, unmapped place, ignored write
    cfg_access(1'b0, 12'h130, 32'h7F00_7F00);
    cfg_access(1'b0, 12'h134, 32'h7F00_7F00);
    cfg_access(1'b0, 12'h138, 32'h0000_0000);
    cfg_access(1'b1, 12'h130, 32'h0000_0000);
    cfg_access(1'b0, 12'h130, 32'h7F00_7F00);
    // Capture frozen by cross-link, then taken once it is off
    lep_link_partner_i.send_ts2(4'b0011, 4'h3, 3'h2);
    cfg_access(1'b0, 12'h130, 32'h7F00_7F00);
    xlink_en = 1'b0;
    lep_link_partner_i.send_ts2(4'b0011, 4'h3, 3'h2);
    lep_link_partner_i.send_ts2(4'b1000, 4'hA, 3'h5);
    cfg_access(1'b0, 12'h130, 32'h2300_2300);
    cfg_access(1'b0, 12'h134, 32'h5A00_7F00);
    // Downstream view, loader for every select code, hint from the partner
    is_ds = 1'b1;
    cfg_access(1'b0, 12'h130, 32'h0000_0000);
    load(2'd1, 2'b00, 4'h5);
    load(2'd2, 2'b01, 4'h9);
    load(2'd3, 2'b10, 4'h6);
    load(2'd0, 2'b11, 4'hF);
    lep_link_partner_i.send_ts2(4'b0101, 4'h7, 3'h3);
    cfg_access(1'b0, 12'h130, 32'h0005_0030);
    cfg_access(1'b0, 12'h134, 32'h6000_0930);
    // A non-transparent port drives nothing toward the link
    {eq_phase1, in_rcvrcfg} = 2'b11;
    repeat (2) @(negedge clk);
    check("tx_preset_r", {16'h0, tx_preset_r}, 32'h0000_0000);
    check("ts2_en_r", {31'h0, ts2_en_r}, 32'h0);
    in_rcvrcfg = 1'b0;
    // Phase 1 applies stored presets, returned hint has no effect
    transparent = 1'b1;
    repeat (2) @(negedge clk);
    eq_phase1 = 1'b0;
    load(2'd1, 2'b00, 4'h1);
    check("tx_preset_r", {16'h0, tx_preset_r}, 32'h0000_0050);
    // TS2s before the speed change, partner adopts them afterwards
    in_rcvrcfg = 1'b1;
    repeat (2) @(negedge clk);
    check("ts2_en_r", {31'h0, ts2_en_r}, 32'h1);
    check("ts2_preset_r", {16'h0, ts2_preset_r}, 32'h0000_0900);
    check("ts2_hint_r", {20'h0, ts2_hint_r}, 32'h0000_0C00);
    in_rcvrcfg = 1'b0;
    repeat (3) @(negedge clk);
    check("adopt_preset", {16'h0, adopt_preset}, 32'h0000_0900);
    check("adopt_hint", {20'h0, adopt_hint}, 32'h0000_0C00);
    // A fundamental reset in mid-run clears the sticky fields
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    check("tx_preset_r", {16'h0, tx_preset_r}, 32'h0000_0000);
    cfg_access(1'b0, 12'h130, 32'h0000_0000);
    summarize();
  end
endmodule

`default_nettype wire
